// *** rtl/upd_top.sv ***
// usb pll configuration and peripheral bus clock divisor registers
// Contract
// - pll output divider code 0..7 gives 1,2,3,4,6,8,12,16
// - pll multiplier code 0..7 gives 15,16,17,18,19,20,21,24
// - pll input divider code 0..7 gives 1,2,3,4,5,6,10,12
// - pll fields load from configuration bits at reset
// - pll config writes ignored unless unlock sequence done
// - pll config unused bits read zero
// - ready flag low while switching; divisor writes then ignored
// - peripheral clock is system clock over 1, 2, 4 or 8
// - divisor writes accepted only after unlock sequence
// - divisor register unused bits read zero
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module upd_top
  import upd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_cfg_out_div,
  input wire logic [2:0] i_cfg_mult,
  input wire logic [2:0] i_cfg_in_div,
  output logic [31:0] o_rdata,
  output logic [3:0] o_pll_in_ratio,
  output logic [4:0] o_pll_mult,
  output logic [4:0] o_pll_out_ratio,
  output logic o_peripheral_clock_en,
  output logic o_divisor_ready,
  output logic o_unlocked
);
  typedef enum logic [1:0] {
    LOCKED,
    KEY1_SEEN,
    OPEN
  } upd_lock_type;

  upd_lock_type lock_q;
  upd_lock_type lock_d;
  logic [2:0] out_div_q;
  logic [2:0] mult_q;
  logic [2:0] in_div_q;
  logic [1:0] bus_sel_q;
  logic [31:0] rdata_q;
  logic [3:0] in_ratio_q;
  logic [4:0] mult_fac_q;
  logic [4:0] out_ratio_q;
  logic unlocked_q;
  logic [8:0] cfg_s;
  logic div_tick;
  logic div_busy;

  // configuration bits come from outside the clock domain
  upd_sync #(
    .WIDTH(9)
  ) u_cfg_sync (
    .i_mclk(i_mclk),
    .i_async({i_cfg_out_div, i_cfg_mult, i_cfg_in_div}),
    .o_sync(cfg_s)
  );

  wire [2:0] cfg_out_s = cfg_s[8:6];
  wire [2:0] cfg_mult_s = cfg_s[5:3];
  wire [2:0] cfg_in_s = cfg_s[2:0];

  // address decode
  wire sel_pll = (i_addr == OFS_PLL_CFG);
  wire sel_pb = (i_addr == OFS_PB_DIV);
  wire sel_key = (i_addr == OFS_UNLOCK);
  wire is_open = (lock_q == OPEN);

  // write strobes; pll and divisor writes need the unlock, key writes do not
  wire wr_pll = i_wr && sel_pll && is_open;
  wire wr_pb = i_wr && sel_pb && is_open && !div_busy;
  wire wr_key = i_wr && sel_key;

  // unlock sequence: key1 then key2 back to back on the key register;
  // any other key write relocks, so stray code closes the door again
  always_comb begin
    lock_d = lock_q;
    if (wr_key) begin
      if (i_wdata == UNLOCK_KEY1) begin
        lock_d = KEY1_SEEN;
      end else if (i_wdata == UNLOCK_KEY2 && lock_q == KEY1_SEEN) begin
        lock_d = OPEN;
      end else begin
        lock_d = LOCKED;
      end
    end else if (i_wr && lock_q == KEY1_SEEN) begin
      lock_d = LOCKED;
    end
    case (lock_d)
      LOCKED: lock_d = LOCKED;
      KEY1_SEEN: lock_d = KEY1_SEEN;
      OPEN: lock_d = OPEN;
      default: lock_d = LOCKED;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      lock_q <= LOCKED;
    end else begin
      lock_q <= lock_d;
    end
  end

  // pll fields: reset takes the synchronised configuration bits
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      out_div_q <= cfg_out_s;
      mult_q <= cfg_mult_s;
      in_div_q <= cfg_in_s;
    end else if (wr_pll) begin
      out_div_q <= i_wdata[POS_OUT_DIV+:3];
      mult_q <= i_wdata[POS_MULT+:3];
      in_div_q <= i_wdata[POS_IN_DIV+:3];
    end
  end

  // divisor select held here, applied by the divider at a period end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      bus_sel_q <= BUS_SEL_RST;
    end else if (wr_pb) begin
      bus_sel_q <= i_wdata[POS_BUS_SEL+:2];
    end
  end

  upd_bus_div u_bus_div (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_sel(bus_sel_q),
    .i_load(wr_pb),
    .o_tick(div_tick),
    .o_busy(div_busy)
  );

  // decoded factors for the analog pll: f = ref / in * mult / out
  wire [3:0] in_ratio_d = upd_in_ratio(in_div_q);
  wire [4:0] mult_fac_d = upd_mult_factor(mult_q);
  wire [4:0] out_ratio_d = upd_out_ratio(out_div_q);

  // read data, reserved bits forced to zero by the layout
  wire [31:0] pll_word = {5'h00, out_div_q, 5'h00, mult_q,
                          5'h00, in_div_q, 8'h00};
  wire [31:0] pb_word = {20'h00000, !div_busy, 9'h000,
                         bus_sel_q};
  wire [31:0] key_word = {31'h0, is_open};
  wire [31:0] rd_val = sel_pll ? pll_word :
                       sel_pb ? pb_word :
                       sel_key ? key_word : ZERO_WORD;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      rdata_q <= ZERO_WORD;
      in_ratio_q <= 4'h1;
      mult_fac_q <= 5'h0F;
      out_ratio_q <= 5'h01;
      unlocked_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rd_val : ZERO_WORD;
      in_ratio_q <= in_ratio_d;
      mult_fac_q <= mult_fac_d;
      out_ratio_q <= out_ratio_d;
      unlocked_q <= is_open;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pll_in_ratio = in_ratio_q;
  assign o_pll_mult = mult_fac_q;
  assign o_pll_out_ratio = out_ratio_q;
  assign o_peripheral_clock_en = div_tick;
  assign o_divisor_ready = !div_busy;
  assign o_unlocked = unlocked_q;

  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  a_pll_locked_hold: assert property (
    (i_wr && sel_pll && !is_open)
      |=> ($stable(out_div_q) && $stable(mult_q) && $stable(in_div_q)))
    else $error("pll config changed while locked");

  a_pb_locked_hold: assert property (
    (i_wr && sel_pb && !is_open) |=> $stable(bus_sel_q))
    else $error("divisor changed while locked");

  a_pb_busy_hold: assert property (
    (i_wr && sel_pb && !o_divisor_ready) |=> $stable(bus_sel_q))
    else $error("divisor changed during a switch");

  a_ready_drops: assert property (
    (i_wr && sel_pb && is_open && o_divisor_ready)
      |=> !o_divisor_ready)
    else $error("ready stayed high after divisor write");

  a_ready_returns: assert property (
    !o_divisor_ready |-> ##[0:8] o_divisor_ready)
    else $error("divisor switch took too long");

  a_pll_read_zero: assert property (
    i_rd && sel_pll |=> (o_rdata & ~PLL_CFG_MASK) == ZERO_WORD)
    else $error("pll config reserved bits not zero");

  a_pb_read_zero: assert property (
    i_rd && sel_pb |=> (o_rdata & ~PB_DIV_MASK) == ZERO_WORD)
    else $error("divisor reserved bits not zero");

  a_pb_ready_read: assert property (
    i_rd && sel_pb |=> o_rdata[POS_DIV_READY] == $past(o_divisor_ready))
    else $error("ready bit read wrong");

  a_out_div_max: assert property (
    (wr_pll && i_wdata[POS_OUT_DIV+:3] == 3'h7)
      |-> ##2 o_pll_out_ratio == 5'h10)
    else $error("output divider code 7 not 16");

  a_out_div_six: assert property (
    (wr_pll && i_wdata[POS_OUT_DIV+:3] == 3'h4)
      |-> ##2 o_pll_out_ratio == 5'h06)
    else $error("output divider code 4 not 6");

  a_mult_ends: assert property (
    (wr_pll && i_wdata[POS_MULT+:3] == 3'h7)
      |-> ##2 o_pll_mult == 5'h18)
    else $error("multiplier code 7 not 24");

  a_mult_base: assert property (
    (wr_pll && i_wdata[POS_MULT+:3] == 3'h0)
      |-> ##2 o_pll_mult == 5'h0F)
    else $error("multiplier code 0 not 15");

  a_in_div_ten: assert property (
    (wr_pll && i_wdata[POS_IN_DIV+:3] == 3'h6)
      |-> ##2 o_pll_in_ratio == 4'hA)
    else $error("input divider code 6 not 10");

  a_cfg_reset_load: assert property (
    $rose(i_nrst) |-> (out_div_q == $past(cfg_out_s)
      && mult_q == $past(cfg_mult_s) && in_div_q == $past(cfg_in_s)))
    else $error("pll fields not loaded from configuration");

  a_reset_ready: assert property (
    $rose(i_nrst) |-> (o_divisor_ready && bus_sel_q == BUS_SEL_RST))
    else $error("divisor reset state wrong");

  a_div8_period: assert property (
    (o_peripheral_clock_en && o_divisor_ready && bus_sel_q == 2'h3)
      |=> (!o_peripheral_clock_en) [*7] ##1 o_peripheral_clock_en)
    else $error("divide by 8 period wrong");

  a_div2_period: assert property (
    (o_peripheral_clock_en && o_divisor_ready && bus_sel_q == 2'h1)
      |=> !o_peripheral_clock_en ##1 o_peripheral_clock_en)
    else $error("divide by 2 period wrong");

  a_div1_steady: assert property (
    (o_divisor_ready && bus_sel_q == 2'h0 && $past(o_divisor_ready)
      && o_peripheral_clock_en) |=> o_peripheral_clock_en)
    else $error("divide by 1 not every cycle");

  c_pll_write: cover property (wr_pll);
  c_pb_switch: cover property (wr_pb ##[1:8] o_divisor_ready);
  c_busy_refused: cover property (i_wr && sel_pb && is_open && div_busy);
  c_locked_write: cover property (i_wr && sel_pll && !is_open);
endmodule

// *** rtl/upd_pkg.sv ***
// shared constants and decode tables for the usb pll and bus divisor block
package upd_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PLL_CFG = 8'h00;
  localparam logic [7:0] OFS_PB_DIV = 8'h10;
  localparam logic [7:0] OFS_UNLOCK = 8'h20;
  localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;
  localparam int POS_OUT_DIV = 24;
  localparam int POS_MULT = 16;
  localparam int POS_IN_DIV = 8;
  localparam int POS_DIV_READY = 11;
  localparam int POS_BUS_SEL = 0;
  localparam int POS_UNLOCKED = 0;
  localparam logic [31:0] PLL_CFG_MASK = 32'h0707_0700;
  localparam logic [31:0] PB_DIV_MASK = 32'h0000_0803;
  localparam logic [1:0] BUS_SEL_RST = 2'h0;
  localparam logic BUS_READY_RST = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // output divider ratio per code
  function automatic logic [4:0] upd_out_ratio(input logic [2:0] code);
    case (code)
      3'h0: upd_out_ratio = 5'h01;
      3'h1: upd_out_ratio = 5'h02;
      3'h2: upd_out_ratio = 5'h03;
      3'h3: upd_out_ratio = 5'h04;
      3'h4: upd_out_ratio = 5'h06;
      3'h5: upd_out_ratio = 5'h08;
      3'h6: upd_out_ratio = 5'h0C;
      default: upd_out_ratio = 5'h10;
    endcase
  endfunction

  // multiplier factor per code
  function automatic logic [4:0] upd_mult_factor(input logic [2:0] code);
    case (code)
      3'h0: upd_mult_factor = 5'h0F;
      3'h1: upd_mult_factor = 5'h10;
      3'h2: upd_mult_factor = 5'h11;
      3'h3: upd_mult_factor = 5'h12;
      3'h4: upd_mult_factor = 5'h13;
      3'h5: upd_mult_factor = 5'h14;
      3'h6: upd_mult_factor = 5'h15;
      default: upd_mult_factor = 5'h18;
    endcase
  endfunction

  // input divider ratio per code
  function automatic logic [3:0] upd_in_ratio(input logic [2:0] code);
    case (code)
      3'h0: upd_in_ratio = 4'h1;
      3'h1: upd_in_ratio = 4'h2;
      3'h2: upd_in_ratio = 4'h3;
      3'h3: upd_in_ratio = 4'h4;
      3'h4: upd_in_ratio = 4'h5;
      3'h5: upd_in_ratio = 4'h6;
      3'h6: upd_in_ratio = 4'hA;
      default: upd_in_ratio = 4'hC;
    endcase
  endfunction
endpackage

// *** rtl/upd_sync.sv ***
// two-flop synchroniser for static configuration levels
`timescale 1ns/1ps
module upd_sync #(
  parameter int WIDTH = 9
) (
  input wire logic i_mclk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // no reset here so the chain is already full when reset loads from it
  always_ff @(posedge i_mclk) begin
    meta_q <= i_async;
    sync_q <= meta_q;
  end

  assign o_sync = sync_q;
endmodule

// *** rtl/upd_bus_div.sv ***
// peripheral clock enable divider with glitch-free ratio switching
`timescale 1ns/1ps
module upd_bus_div
  import upd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [1:0] i_sel,
  input wire logic i_load,
  output logic o_tick,
  output logic o_busy
);
  logic [1:0] act_q;
  logic [1:0] act_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic pend_q;
  logic pend_d;
  logic tick_q;
  wire [2:0] cnt_max = 3'((4'h1 << act_q) - 4'h1);
  wire at_end = (cnt_q == cnt_max);

  // a new ratio waits for the current period to end, never a short pulse
  assign pend_d = i_load ? 1'b1 : (at_end ? 1'b0 : pend_q);
  assign act_d = (at_end && pend_q) ? i_sel : act_q;
  assign cnt_d = at_end ? 3'h0 : cnt_q + 3'h1;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      act_q <= BUS_SEL_RST;
      cnt_q <= 3'h0;
      pend_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      act_q <= act_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      tick_q <= at_end;
    end
  end

  assign o_tick = tick_q;
  assign o_busy = pend_q;
endmodule

// *** tb/upd_top_tb.sv ***
// self-checking bench for the pll configuration and bus divisor block
`timescale 1ns/1ps
module upd_top_tb
  import upd_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_cfg_out_div = 3'h0;
  logic [2:0] i_cfg_mult = 3'h0;
  logic [2:0] i_cfg_in_div = 3'h0;
  logic [31:0] o_rdata;
  logic [3:0] o_pll_in_ratio;
  logic [4:0] o_pll_mult;
  logic [4:0] o_pll_out_ratio;
  logic o_peripheral_clock_en;
  logic o_divisor_ready;
  logic o_unlocked;
  // bench model: ratio tables and register shadows
  int out_tab[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  int mult_tab[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  int in_tab[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  logic [2:0] m_out;
  logic [2:0] m_mult;
  logic [2:0] m_in;
  logic [1:0] m_sel;
  logic m_unl;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rng = 32'h0000_0029;
  logic [31:0] v;

  upd_top i_upd_top (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_cfg_out_div(i_cfg_out_div),
    .i_cfg_mult(i_cfg_mult),
    .i_cfg_in_div(i_cfg_in_div),
    .o_rdata(o_rdata),
    .o_pll_in_ratio(o_pll_in_ratio),
    .o_pll_mult(o_pll_mult),
    .o_pll_out_ratio(o_pll_out_ratio),
    .o_peripheral_clock_en(o_peripheral_clock_en),
    .o_divisor_ready(o_divisor_ready),
    .o_unlocked(o_unlocked)
  );

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready is sampled where the write edge will see it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    #1 rdy = o_divisor_ready;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a == OFS_PLL_CFG && m_unl) begin
      m_out = d[26:24];
      m_mult = d[18:16];
      m_in = d[10:8];
    end
    if (a == OFS_PB_DIV && m_unl && rdy === 1'b1) begin
      m_sel = d[1:0];
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk_regs;
    logic [31:0] d;
    rd(OFS_PLL_CFG, d);
    chk("pll_cfg", d, {5'h00, m_out, 5'h00, m_mult, 5'h00, m_in, 8'h00});
    chk("out_ratio", 32'(o_pll_out_ratio), out_tab[m_out]);
    chk("mult", 32'(o_pll_mult), mult_tab[m_mult]);
    chk("in_ratio", 32'(o_pll_in_ratio), in_tab[m_in]);
    rd(OFS_PB_DIV, d);
    chk("pb_div", d, {20'h00000, 1'b1, 9'h000, m_sel});
  endtask

  task automatic do_reset(input logic [2:0] o, input logic [2:0] m,
                          input logic [2:0] n);
    @(posedge i_mclk);
    i_cfg_out_div <= o;
    i_cfg_mult <= m;
    i_cfg_in_div <= n;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    m_out = o;
    m_mult = m;
    m_in = n;
    m_sel = 2'h0;
    m_unl = 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask

  // bounded waits; the enable period must match the selected ratio
  task automatic chk_period;
    int t;
    int n;
    t = 0;
    while (o_divisor_ready !== 1'b1 && t < 50) begin
      @(posedge i_mclk);
      #1 t++;
    end
    chk("ready", 32'(o_divisor_ready), 1);
    t = 0;
    do begin
      @(posedge i_mclk);
      #1 t++;
    end while (o_peripheral_clock_en !== 1'b1 && t < 20);
    n = 0;
    do begin
      @(posedge i_mclk);
      #1 n++;
    end while (o_peripheral_clock_en !== 1'b1 && n < 20);
    chk("period", n, 1 << m_sel);
  endtask

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    for (int k = 0; k < 8; k++) begin
      do_reset(3'(k), 3'(7 - k), 3'(k + 2));
      chk_regs();
      chk("unlocked", 32'(o_unlocked), 0);
    end
    rng = xs(rng);
    i_cfg_out_div <= rng[2:0];
    i_cfg_mult <= rng[5:3];
    i_cfg_in_div <= rng[8:6];
    // config pins are only sampled during reset
    repeat (4) @(posedge i_mclk);
    chk_regs();
    wr(OFS_PLL_CFG, xs(rng));
    wr(OFS_PB_DIV, 32'h0000_0003);
    chk_regs();
    // an intervening write breaks the key pair
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_PLL_CFG, 32'h0000_0100);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    chk_regs();
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    m_unl = 1'b1;
    @(posedge i_mclk);
    #1 chk("unlocked", 32'(o_unlocked), 1);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      wr(OFS_PLL_CFG, rng);
      repeat (2) @(posedge i_mclk);
      chk_regs();
    end
    // fixed codes so every code the ratio assertions check is always reached
    wr(OFS_PLL_CFG, 32'h0407_0600);
    chk_regs();
    wr(OFS_PLL_CFG, 32'h0700_0000);
    chk_regs();
    for (int j = 3; j >= 0; j--) begin
      rng = xs(rng);
      wr(OFS_PB_DIV, {rng[31:2], 2'(j)});
      // pending is set by the accepting edge whatever the old phase
      #1 chk("busy", 32'(o_divisor_ready), 0);
      // may land while switching and then must be dropped
      wr(OFS_PB_DIV, {rng[31:2], 2'(j + 1)});
      chk_period();
      chk_period();
      chk_regs();
    end
    wr(OFS_UNLOCK, ZERO_WORD);
    m_unl = 1'b0;
    @(posedge i_mclk);
    #1 chk("unlocked", 32'(o_unlocked), 0);
    wr(OFS_PB_DIV, 32'h0000_0002);
    chk_regs();
    rd(8'h30, v);
    chk("unmapped", v, ZERO_WORD);
    tally_and_finish();
  end
endmodule
